/* File: include/spm_pkg.sv */
// Purpose: shared constants and types of the serial peripheral port
// Assumes: 6-bit i/o register address space, 8-bit data
// Notes: control and data offsets sit next to the status register

package spm_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [5:0] SPM_OFS_CTRL = 6'h0d;
    localparam logic [5:0] SPM_OFS_STAT = 6'h0e;
    localparam logic [5:0] SPM_OFS_DATA = 6'h0f;

    // ****************************************
    // control fields
    // ****************************************
    localparam int SPM_C_IRQEN = 7;
    localparam int SPM_C_EN = 6;
    localparam int SPM_C_DATA_ORDER = 5;
    localparam int SPM_C_MASTER_SELECT = 4;
    localparam int SPM_C_CLOCK_POLARITY = 3;
    localparam int SPM_C_CLOCK_PHASE_SEL = 2;
    localparam int SPM_C_RATE_HI = 1;
    localparam int SPM_C_RATE_LO = 0;
    localparam logic [7:0] SPM_CTRL_RST = 8'h00;

    // ****************************************
    // status fields
    // ****************************************
    localparam int SPM_S_DONE = 7;
    localparam int SPM_S_WRITE_COLLISION_FLAG = 6;
    localparam logic [7:0] SPM_STAT_RST = 8'h00;

    // ****************************************
    // pin index in user direction vector
    // ****************************************
    localparam int SPM_P_MOSI = 0;
    localparam int SPM_P_MISO = 1;
    localparam int SPM_P_SCK = 2;
    localparam int SPM_P_SS = 3;

    // ****************************************
    // sck half periods minus one, per rate select
    // ****************************************
    localparam logic [5:0] SPM_HALF_DIV4 = 6'h01;
    localparam logic [5:0] SPM_HALF_DIV16 = 6'h07;
    localparam logic [5:0] SPM_HALF_DIV64 = 6'h1f;
    localparam logic [5:0] SPM_HALF_DIV128 = 6'h3f;
    localparam logic [3:0] SPM_LAST_EDGE = 4'hf;

    typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} spm_state_e;

endpackage

/* File: logic/spm_port.sv */
// Purpose: serial peripheral port, master or slave, on the i/o register port
// Assumes: pins arrive asynchronously; user directions come from port logic
// Notes: pin outputs are registered; a fault abandons the byte in flight

`timescale 1ns/1ps

module spm_port
    import spm_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // i/o register port
    input wire logic [5:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    // interrupt handshake with the core
    input wire logic GLOBAL_IE,
    input wire logic IRQ_ACK,
    output logic IRQ,
    // user pin directions and general output value of ss
    input wire logic [3:0] USER_DIR,
    input wire logic SS_GPO,
    // pins
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    input wire logic SS_I,
    output logic SS_O,
    output logic SS_OE
);

    typedef struct packed {
        spm_state_e st;
        logic [7:0] ctrl;
        logic transfer_done_flag;
        logic write_collision_flag;
        logic arm_transfer_done_flag;
        logic arm_write_collision_flag;
        logic [7:0] sr;
        logic rx_bit;
        logic rx_pend;
        logic fin_pend;
        logic [7:0] rx_buf;
        logic [5:0] div_cnt;
        logic [3:0] edge_cnt;
        logic sck_lvl;
        logic sck_prev;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] pin_o;
    } spm_state_s;

    spm_state_s q;
    spm_state_s n;
    logic [3:0] pin_s;
    logic mosi_s;
    logic miso_s;
    logic sck_s;
    logic ss_s;
    logic mode_fault;
    logic data_wr;
    logic data_acc;
    logic stat_rd;
    logic busy;
    logic edge_now;
    logic sample;
    logic din;
    logic xfer_done;
    logic last_edge;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [5:0] half_of(input logic [1:0] rate);
        case (rate)
            2'h0: half_of = SPM_HALF_DIV4;
            2'h1: half_of = SPM_HALF_DIV16;
            2'h2: half_of = SPM_HALF_DIV64;
            default: half_of = SPM_HALF_DIV128;
        endcase
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    spm_sync #(.WIDTH(4)) u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .D({SS_I, SCK_I, MISO_I, MOSI_I}),
        .Q(pin_s)
    );

    assign mosi_s = pin_s[SPM_P_MOSI];
    assign miso_s = pin_s[SPM_P_MISO];
    assign sck_s = pin_s[SPM_P_SCK];
    assign ss_s = pin_s[SPM_P_SS];

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        n = q;
        n.sck_prev = sck_s;
        edge_now = 1'b0;
        xfer_done = 1'b0;
        last_edge = 1'b0;
        data_wr = IO_WR && (IO_ADDR == SPM_OFS_DATA);
        data_acc = data_wr || (IO_RD && (IO_ADDR == SPM_OFS_DATA));
        stat_rd = IO_RD && (IO_ADDR == SPM_OFS_STAT);
        // ss low with ss as input while master means another master took the bus
        mode_fault = q.ctrl[SPM_C_EN] && q.ctrl[SPM_C_MASTER_SELECT] && !USER_DIR[SPM_P_SS]
            && !ss_s;
        busy = (q.st == ST_MASTER) || ((q.st == ST_SLAVE) && (q.edge_cnt != 4'h0))
            || q.fin_pend;
        sample = 1'b0;
        din = (q.st == ST_MASTER) ? miso_s : mosi_s;

        // clears go first so that a same-cycle set wins
        if (stat_rd)
        begin
            n.arm_transfer_done_flag = q.transfer_done_flag;
            n.arm_write_collision_flag = q.write_collision_flag;
        end
        if (data_acc)
        begin
            if (q.arm_transfer_done_flag || q.arm_write_collision_flag)
            begin
                n.transfer_done_flag = 1'b0;
            end
            if (q.arm_write_collision_flag)
            begin
                n.write_collision_flag = 1'b0;
            end
            n.arm_transfer_done_flag = 1'b0;
            n.arm_write_collision_flag = 1'b0;
        end
        if (IRQ_ACK)
        begin
            n.transfer_done_flag = 1'b0;
        end

        // master miso is taken one cycle after its edge: the synchroniser lags our own sck
        if (q.rx_pend)
        begin
            n.rx_bit = miso_s;
            n.rx_pend = 1'b0;
        end
        if (q.fin_pend)
        begin
            n.sr = shift_in(q.sr, q.rx_pend ? miso_s : q.rx_bit, q.ctrl[SPM_C_DATA_ORDER]);
            n.rx_buf = n.sr;
            n.transfer_done_flag = 1'b1;
            n.fin_pend = 1'b0;
            xfer_done = 1'b1;
        end

        if (IO_WR && (IO_ADDR == SPM_OFS_CTRL))
        begin
            n.ctrl = IO_WDATA;
        end

        case (q.st)
            ST_IDLE:
            begin
                n.edge_cnt = 4'h0;
                if (q.ctrl[SPM_C_EN] && !q.ctrl[SPM_C_MASTER_SELECT] && !ss_s)
                begin
                    n.st = ST_SLAVE;
                end
            end
            ST_MASTER:
            begin
                if (q.div_cnt == 6'h00)
                begin
                    n.div_cnt = half_of(q.ctrl[SPM_C_RATE_HI:SPM_C_RATE_LO]);
                    n.sck_lvl = !q.sck_lvl;
                    edge_now = 1'b1;
                end
                else
                begin
                    n.div_cnt = q.div_cnt - 6'h01;
                end
            end
            ST_SLAVE:
            begin
                // slave timing follows the external clock only
                if (ss_s || !q.ctrl[SPM_C_EN])
                begin
                    n.st = ST_IDLE;
                    n.edge_cnt = 4'h0;
                end
                else
                begin
                    edge_now = (sck_s != q.sck_prev);
                end
            end
            default:
            begin
                n.st = ST_IDLE;
            end
        endcase

        if (edge_now)
        begin
            // even edges leave the idle level
            sample = !q.edge_cnt[0] ^ q.ctrl[SPM_C_CLOCK_PHASE_SEL];
            last_edge = (q.edge_cnt == SPM_LAST_EDGE);
            if (sample && (q.st == ST_MASTER))
            begin
                n.rx_pend = 1'b1;
            end
            else if (sample)
            begin
                n.rx_bit = din;
            end
            if (last_edge)
            begin
                // the last bit is merged a cycle later, so mosi holds still on this edge
                n.fin_pend = 1'b1;
                n.st = (q.st == ST_MASTER) ? ST_IDLE : ST_SLAVE;
                n.edge_cnt = 4'h0;
            end
            else
            begin
                if (!sample && !(q.ctrl[SPM_C_CLOCK_PHASE_SEL] && (q.edge_cnt == 4'h0)))
                begin
                    n.sr = shift_in(q.sr, q.rx_bit, q.ctrl[SPM_C_DATA_ORDER]);
                end
                n.edge_cnt = q.edge_cnt + 4'h1;
            end
        end

        if (data_wr)
        begin
            if (busy)
            begin
                n.write_collision_flag = 1'b1;
            end
            else
            begin
                n.sr = IO_WDATA;
                if (q.ctrl[SPM_C_EN] && q.ctrl[SPM_C_MASTER_SELECT] && !mode_fault)
                begin
                    n.st = ST_MASTER;
                    n.div_cnt = half_of(q.ctrl[SPM_C_RATE_HI:SPM_C_RATE_LO]);
                    n.edge_cnt = 4'h0;
                end
            end
        end

        if (mode_fault)
        begin
            n.ctrl[SPM_C_MASTER_SELECT] = 1'b0;
            n.transfer_done_flag = 1'b1;
            n.rx_pend = 1'b0;
            n.fin_pend = 1'b0;
            n.st = ST_IDLE;
            n.edge_cnt = 4'h0;
        end
        if (!n.ctrl[SPM_C_EN] && (n.st == ST_MASTER))
        begin
            n.st = ST_IDLE;
        end
        if (n.st != ST_MASTER)
        begin
            n.sck_lvl = n.ctrl[SPM_C_CLOCK_POLARITY];
        end

        if (IO_RD)
        begin
            case (IO_ADDR)
                SPM_OFS_CTRL: n.rdata = q.ctrl;
                SPM_OFS_STAT: n.rdata = {q.transfer_done_flag, q.write_collision_flag, 6'h00};
                SPM_OFS_DATA: n.rdata = q.rx_buf;
                default: n.rdata = 8'h00;
            endcase
        end

        n.irq = q.transfer_done_flag && q.ctrl[SPM_C_IRQEN] && GLOBAL_IE;

        // pin drive: {ss, sck, miso, mosi} values then enables
        n.pin_o = 8'h00;
        if (n.ctrl[SPM_C_EN] && n.ctrl[SPM_C_MASTER_SELECT])
        begin
            n.pin_o[0] = n.ctrl[SPM_C_DATA_ORDER] ? n.sr[0] : n.sr[7];
            n.pin_o[2] = n.sck_lvl;
            n.pin_o[3] = SS_GPO;
            n.pin_o[4] = USER_DIR[SPM_P_MOSI];
            n.pin_o[6] = USER_DIR[SPM_P_SCK];
            n.pin_o[7] = USER_DIR[SPM_P_SS];
        end
        else if (n.ctrl[SPM_C_EN])
        begin
            n.pin_o[1] = n.ctrl[SPM_C_DATA_ORDER] ? n.sr[0] : n.sr[7];
            n.pin_o[5] = USER_DIR[SPM_P_MISO] && !ss_s;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            q <= '{st: ST_IDLE, ctrl: SPM_CTRL_RST, transfer_done_flag: SPM_STAT_RST[SPM_S_DONE],
                   write_collision_flag: SPM_STAT_RST[SPM_S_WRITE_COLLISION_FLAG], sck_prev: 1'b1, default: '0};
        end
        else
        begin
            q <= n;
        end
    end

    assign IO_RDATA = q.rdata;
    assign IRQ = q.irq;
    assign MOSI_O = q.pin_o[0];
    assign MISO_O = q.pin_o[1];
    assign SCK_O = q.pin_o[2];
    assign SS_O = q.pin_o[3];
    assign MOSI_OE = q.pin_o[4];
    assign MISO_OE = q.pin_o[5];
    assign SCK_OE = q.pin_o[6];
    assign SS_OE = q.pin_o[7];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    logic [11:0] mcyc_q;
    always_ff @(posedge CLK)
    begin
        if (!NRST || (q.st != ST_MASTER))
        begin
            mcyc_q <= 12'h000;
        end
        else
        begin
            mcyc_q <= mcyc_q + 12'h001;
        end
    end

    property p_rsvd;
        (IO_RD && (IO_ADDR == SPM_OFS_STAT)) |=> (IO_RDATA[5:0] == 6'h00);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("status reserved bits not zero");

    property p_miso_in;
        (q.ctrl[SPM_C_EN] && q.ctrl[SPM_C_MASTER_SELECT]) |-> !MISO_OE;
    endproperty
    a_miso_in: assert property (p_miso_in) else $error("miso driven in master");

    property p_slave_in;
        (q.ctrl[SPM_C_EN] && !q.ctrl[SPM_C_MASTER_SELECT]) |-> !(MOSI_OE || SCK_OE || SS_OE);
    endproperty
    a_slave_in: assert property (p_slave_in) else $error("slave drives input pin");

    property p_fault;
        mode_fault |=> (!q.ctrl[SPM_C_MASTER_SELECT] && q.transfer_done_flag && (q.st == ST_IDLE));
    endproperty
    a_fault: assert property (p_fault) else $error("ss fault not handled");

    property p_stay_slave;
        (!q.ctrl[SPM_C_MASTER_SELECT] && !(IO_WR && (IO_ADDR == SPM_OFS_CTRL)))
            |=> !q.ctrl[SPM_C_MASTER_SELECT];
    endproperty
    a_stay_slave: assert property (p_stay_slave) else $error("master set by itself");

    property p_write_collision_flag;
        (data_wr && busy) |=> (q.write_collision_flag && $stable(q.st));
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

    property p_irq;
        (q.transfer_done_flag && q.ctrl[SPM_C_IRQEN] && GLOBAL_IE) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_ack;
        (IRQ_ACK && !xfer_done && !mode_fault) |=> !q.transfer_done_flag;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear flag");

    property p_sck_idle;
        (q.st != ST_MASTER) |-> (q.sck_lvl == q.ctrl[SPM_C_CLOCK_POLARITY]);
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck idle level wrong");

    property p_xfer_len;
        (last_edge && (q.st == ST_MASTER)) |->
            ((mcyc_q + 12'h001) == 12'(16 * (half_of(q.ctrl[1:0]) + 7'h01)));
    endproperty
    a_xfer_len: assert property (p_xfer_len) else $error("master byte length wrong");

    c_master: cover property (last_edge && (q.st == ST_MASTER));
    c_slave: cover property (last_edge && (q.st == ST_SLAVE));
    c_fault: cover property (mode_fault);
    c_write_collision_flag: cover property (data_wr && busy);

endmodule

/* File: logic/spm_sync.sv */
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs are asynchronous to CLK
// Notes: only the second stage may be read by other logic

`timescale 1ns/1ps

module spm_sync
    import spm_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // pins
    input wire logic [WIDTH-1:0] D,
    output logic [WIDTH-1:0] Q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // idle pin level is high, so reset to ones avoids a false fault
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= D;
            sync_q <= meta_q;
        end
    end

    assign Q = sync_q;

endmodule

/* File: verification/spm_peer.sv */
// Purpose: behavioural far-side slave for the serial port bench
// Assumes: clocked by the port's registered master pins, selected by the bench
// Notes: a released miso shows the inverse of its last bit, never a held value

`timescale 1ns/1ps

module spm_peer
(
    // serial pins
    input wire logic SCK,
    input wire logic MOSI,
    input wire logic SEL_N,
    output logic MISO,
    // frame setup
    input wire logic CLOCK_POLARITY,
    input wire logic CLOCK_PHASE_SEL,
    input wire logic LSB,
    input wire logic [7:0] TX,
    output logic [7:0] RX
);
    // ****
    // shifter
    // ****
    int k;

    initial
    begin
        MISO = 1'b1;
        RX = 8'h00;
        k = 0;
    end

    task automatic put();
        MISO = LSB ? TX[k] : TX[7 - k];
        k = k + 1;
    endtask

    // phase 0 must show its first bit before any clock edge
    always @(negedge SEL_N)
    begin
        k = 0;
        if (!CLOCK_PHASE_SEL)
            put();
    end

    always @(SCK)
    begin
        if (!SEL_N && ((SCK != CLOCK_POLARITY) != CLOCK_PHASE_SEL))
            RX = LSB ? {MOSI, RX[7:1]} : {RX[6:0], MOSI};
        else if (!SEL_N && k < 8)
            put();
    end

    always @(posedge SEL_N)
        MISO = ~MISO;
endmodule

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the serial peripheral port
// Assumes: register port driven on falling edges, far side is spm_peer
// Notes: slave traffic is bit-banged by the bench at a slow pace

`timescale 1ns/1ps

module testbench
    import spm_pkg::*;
;
    typedef struct {logic [7:0] ctrl; logic [7:0] tx; logic [7:0] rx; int half;} spm_row_s;
    logic clk, nrst, io_wr, io_rd, global_ie, irq_ack, ss_gpo, irq, peer_miso;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, rd_v, peer_tx, peer_rx, got;
    logic [3:0] user_dir;
    logic mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_o, ss_oe;
    logic tb_sck, tb_mosi, tb_ss, peer_sel_n, peer_clock_polarity, peer_clock_phase_sel, peer_lsb, sck_prev;
    int num_errors, n_checks, cnt, half_seen, toggles;
    spm_row_s rows[4];

    spm_port i_dut(.CLK(clk), .NRST(nrst), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
        .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .GLOBAL_IE(global_ie), .IRQ_ACK(irq_ack),
        .IRQ(irq), .USER_DIR(user_dir), .SS_GPO(ss_gpo), .MOSI_I(tb_mosi), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MISO_I(peer_miso), .MISO_O(miso_o), .MISO_OE(miso_oe),
        .SCK_I(tb_sck), .SCK_O(sck_o), .SCK_OE(sck_oe), .SS_I(tb_ss), .SS_O(ss_o),
        .SS_OE(ss_oe));

    spm_peer i_peer(.SCK(sck_o), .MOSI(mosi_o), .SEL_N(peer_sel_n), .MISO(peer_miso),
        .CLOCK_POLARITY(peer_clock_polarity), .CLOCK_PHASE_SEL(peer_clock_phase_sel), .LSB(peer_lsb), .TX(peer_tx), .RX(peer_rx));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****
    // sck half period and edge count
    // ****
    always @(posedge clk)
    begin
        if (sck_o !== sck_prev)
        begin
            half_seen <= cnt;
            cnt <= 1;
            toggles <= toggles + 1;
        end
        else
            cnt <= cnt + 1;
        sck_prev <= sck_o;
    end

    // ****
    // helpers
    // ****
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        // an idle edge keeps a following call from raising the strobe at the same instant
        @(negedge clk);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
        @(negedge clk);
    endtask

    // polling the status also arms the flag clear, which the callers rely on
    task automatic wait_done(output logic [7:0] s);
        s = 8'h00;
        for (int i = 0; i < 2000 && s[7] !== 1'b1; i++)
            rd(SPM_OFS_STAT, s);
    endtask

    task automatic peer_on(input logic [7:0] c, input logic [7:0] b);
        peer_clock_polarity = c[SPM_C_CLOCK_POLARITY];
        peer_clock_phase_sel = c[SPM_C_CLOCK_PHASE_SEL];
        peer_lsb = c[SPM_C_DATA_ORDER];
        peer_tx = b;
        peer_sel_n = 1'b0;
        idle(2);
    endtask

    task automatic run_row(input spm_row_s r);
        wr(SPM_OFS_CTRL, r.ctrl);
        idle(4);
        chk(8'(sck_o), 8'(r.ctrl[SPM_C_CLOCK_POLARITY]), "sck idle level");
        chk(8'({sck_oe, miso_oe}), 8'h02, "master pin directions");
        peer_on(r.ctrl, r.rx);
        toggles = 0;
        wr(SPM_OFS_DATA, r.tx);
        wait_done(rd_v);
        chk(rd_v, 8'h80, "done flag");
        chk(8'(toggles), 8'd16, "sck edge count");
        chk(8'(half_seen), 8'(r.half), "sck half period");
        chk(peer_rx, r.tx, "byte on mosi");
        rd(SPM_OFS_DATA, rd_v);
        chk(rd_v, r.rx, "byte from miso");
        rd(SPM_OFS_STAT, rd_v);
        chk(rd_v, 8'h00, "done cleared");
        peer_sel_n = 1'b1;
    endtask

    initial
    begin
        #(20000 * 50);
        num_errors++;
        give_verdict();
    end

    // ****
    // main sequence
    // ****
    initial
    begin
        {nrst, io_wr, io_rd, global_ie, irq_ack, ss_gpo, tb_sck, tb_mosi} = 8'h00;
        {tb_ss, peer_sel_n, peer_clock_polarity, peer_clock_phase_sel, peer_lsb, sck_prev} = 6'b110000;
        io_addr = 6'h00;
        io_wdata = 8'h00;
        peer_tx = 8'h00;
        user_dir = 4'h5;
        num_errors = 0;
        n_checks = 0;
        cnt = 0;
        half_seen = 0;
        toggles = 0;
        rows = '{'{8'h50, 8'ha5, 8'h3c, 2}, '{8'h59, 8'h81, 8'h7e, 8},
                 '{8'h76, 8'h01, 8'hc2, 32}, '{8'h7f, 8'h5a, 8'h96, 64}};
        idle(3);
        nrst = 1'b1;
        chk(8'({irq, mosi_oe, miso_oe, sck_oe, ss_oe}), 8'h00, "outputs after reset");
        rd(SPM_OFS_STAT, rd_v);
        chk(rd_v, SPM_STAT_RST, "status reset");
        rd(SPM_OFS_CTRL, rd_v);
        chk(rd_v, SPM_CTRL_RST, "control reset");
        rd(6'h3f, rd_v);
        chk(rd_v, 8'h00, "unmapped read");
        wr(SPM_OFS_STAT, 8'hff);
        rd(SPM_OFS_STAT, rd_v);
        chk(rd_v, 8'h00, "status read only");
        foreach (rows[i])
            run_row(rows[i]);
        // a second write mid-transfer is dropped and flagged
        wr(SPM_OFS_CTRL, 8'h53);
        peer_on(8'h53, 8'h69);
        wr(SPM_OFS_DATA, 8'h3c);
        idle(20);
        wr(SPM_OFS_DATA, 8'hff);
        wait_done(rd_v);
        chk(rd_v, 8'hc0, "collision flag");
        chk(peer_rx, 8'h3c, "first byte kept");
        rd(SPM_OFS_DATA, rd_v);
        rd(SPM_OFS_STAT, rd_v);
        chk(rd_v, 8'h00, "both flags cleared");
        // interrupt raised then acknowledged
        global_ie = 1'b1;
        wr(SPM_OFS_CTRL, 8'hd0);
        wr(SPM_OFS_DATA, 8'h11);
        for (int i = 0; i < 200 && irq !== 1'b1; i++)
            @(negedge clk);
        chk(8'(irq), 8'h01, "irq raised");
        irq_ack = 1'b1;
        idle(1);
        irq_ack = 1'b0;
        idle(2);
        rd(SPM_OFS_STAT, rd_v);
        chk({rd_v[7:1], irq}, 8'h00, "ack clears done");
        peer_sel_n = 1'b1;
        // ss as output, then as input pulled low
        user_dir = 4'hf;
        ss_gpo = 1'b1;
        wr(SPM_OFS_CTRL, 8'h50);
        tb_ss = 1'b0;
        idle(6);
        rd(SPM_OFS_CTRL, rd_v);
        chk(rd_v, 8'h50, "ss output keeps master");
        chk(8'({ss_oe, ss_o, miso_oe}), 8'h06, "ss general output");
        user_dir = 4'h7;
        idle(6);
        rd(SPM_OFS_CTRL, rd_v);
        chk(rd_v, 8'h40, "mode fault to slave");
        chk(8'({mosi_oe, sck_oe}), 8'h00, "fault pin directions");
        rd(SPM_OFS_STAT, rd_v);
        chk(rd_v, 8'h80, "fault sets done");
        rd(SPM_OFS_DATA, rd_v);
        tb_ss = 1'b1;
        idle(6);
        rd(SPM_OFS_CTRL, rd_v);
        chk(rd_v, 8'h40, "stays slave");
        // slave byte clocked by the bench, rate bits set but unused
        user_dir = 4'hf;
        wr(SPM_OFS_CTRL, 8'h43);
        wr(SPM_OFS_DATA, 8'hc6);
        chk(8'({mosi_oe, sck_oe, ss_oe, miso_oe}), 8'h00, "slave unselected");
        tb_ss = 1'b0;
        idle(4);
        chk(8'(miso_oe), 8'h01, "selected slave drives");
        for (int i = 7; i >= 0; i--)
        begin
            tb_mosi = 1'(8'h9b >> i);
            idle(8);
            got[i] = miso_o;
            tb_sck = 1'b1;
            idle(8);
            tb_sck = 1'b0;
            idle(8);
        end
        chk(got, 8'hc6, "slave byte on miso");
        wait_done(rd_v);
        chk(rd_v, 8'h80, "slave done");
        rd(SPM_OFS_DATA, rd_v);
        chk(rd_v, 8'h9b, "slave byte in");
        tb_ss = 1'b1;
        idle(4);
        // reset in the middle of a master byte drops it and restores every register
        wr(SPM_OFS_CTRL, 8'h5c);
        wr(SPM_OFS_DATA, 8'h5a);
        idle(5);
        nrst = 1'b0;
        idle(3);
        nrst = 1'b1;
        chk(8'({sck_o, mosi_oe, sck_oe, ss_oe, irq}), 8'h00, "outputs after second reset");
        rd(SPM_OFS_CTRL, rd_v);
        chk(rd_v, SPM_CTRL_RST, "control after second reset");
        rd(SPM_OFS_STAT, rd_v);
        chk(rd_v, SPM_STAT_RST, "status after second reset");
        give_verdict();
    end
endmodule
